// ### hdl/rdc_dma_command.sv
/*
  Receive descriptor decoder and DMA command register for a two-channel
  bus-master network controller. Holds the control register map and the
  configuration space. Assumes the bus-facing target logic delivers
  single-cycle register requests on clk, and that the DMA engines report
  descriptor fetches as single-cycle strobes on the same clock.
*/
`timescale 1ns/1ps
module rdc_dma_command #(
  parameter int FIFO_WIDTH = $bits(rdc_pkg::rdc_job_type),
  parameter int FIFO_DEPTH = rdc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire rdc_pkg::rdc_req_type ctl_req,
  output logic [31:0] ctl_rdata,
  input wire rdc_pkg::rdc_req_type cfg_req,
  output logic [31:0] cfg_rdata,
  input wire logic test_mode,
  input wire logic rx_desc_valid,
  output logic rx_desc_ready,
  input wire rdc_pkg::rdc_desc_type rx_desc,
  output logic rx_job_valid,
  input wire logic rx_job_ready,
  output rdc_pkg::rdc_job_type rx_job,
  output logic rx_owned_fetch,
  input wire logic tx_desc_fetch,
  input wire logic tx_desc_owned,
  input wire logic tx_underrun_event,
  input wire logic rx_status_valid,
  input wire logic [31:0] rx_status_word,
  input wire logic [31:0] tx_status_word,
  output logic receiver_online,
  output logic receive_dma_halt,
  output logic transmit_dma_halt,
  output logic underrun_restart,
  output logic skip_current_frame,
  output logic receive_descriptors_queued,
  output logic transmit_descriptors_queued
);
  // ==========================================================================
  // Register decode.
  logic ctl_wr;
  logic cmd_wr;
  logic [31:0] wdata;
  logic [31:0] interrupt_status_reg;
  logic [15:0] interrupt_mask;
  logic [31:0] general_control;
  logic [31:0] burst_length_count;
  logic [31:0] receive_config;
  logic [31:0] transmit_config;
  logic [31:0] rx_first_desc;
  logic [31:0] rx_current_desc;
  logic [31:0] rx_copy_threshold;
  logic [31:0] preemptive_int;
  logic [31:0] tx_first_desc;
  logic [31:0] tx_current_desc;
  logic [31:0] early_tx_threshold;
  logic [31:0] cfg_int_line;
  logic rx_fetch;
  logic rx_host_owned;

  // Control map is dword-only; partial enables are dropped rather than
  // merged, since the host never issues them.
  assign ctl_wr = ctl_req.valid && ctl_req.write && (ctl_req.be == 4'hf);
  assign cmd_wr = ctl_wr && (ctl_req.addr == rdc_pkg::OFF_DMA_COMMAND);
  assign wdata = ctl_req.wdata;

  function automatic logic hit(input logic [7:0] off);
    hit = ctl_wr && (ctl_req.addr == off);
  endfunction : hit

  // ==========================================================================
  // Descriptor path: decoded jobs wait in a FIFO for the copy engine.
  logic fifo_in_ready;
  logic [FIFO_WIDTH-1:0] fifo_out;
  rdc_pkg::rdc_job_type next_job;

  assign rx_fetch = rx_desc_valid && rx_desc_ready;
  assign rx_host_owned = !rx_desc.status[rdc_pkg::DW0_OWNER];
  // Host-owned descriptors are never queued, so they need no FIFO room.
  assign rx_desc_ready = fifo_in_ready || rx_host_owned;
  assign rx_owned_fetch = rx_fetch && !rx_host_owned;

  always_comb begin
    next_job = '0;
    next_job.header_copy = rx_desc.control[rdc_pkg::DW2_HEADER_COPY];
    next_job.length_first = rx_desc.control[rdc_pkg::DW2_LENGTH_FIRST];
    next_job.fragment_list = rx_desc.control[rdc_pkg::DW2_FRAGMENT_LIST];
    // Same field, two meanings, chosen by the fragment-list bit.
    if (rx_desc.control[rdc_pkg::DW2_FRAGMENT_LIST]) begin
      next_job.offset = rx_desc.control[15:0];
      // Fragment lists are dword aligned by the host.
      next_job.address = rx_desc.buffer;
    end else begin
      next_job.length = rx_desc.control[15:0];
      next_job.address = rx_desc.buffer;
    end
    next_job.next_desc = rx_desc.next & rdc_pkg::DW3_ALIGN_MASK;
  end

  rdc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_desc_valid && !rx_host_owned),
    .in_ready(fifo_in_ready),
    .in_data(FIFO_WIDTH'(next_job)),
    .out_valid(rx_job_valid),
    .out_ready(rx_job_ready),
    .out_data(fifo_out)
  );
  assign rx_job = rdc_pkg::rdc_job_type'(fifo_out);

  // ==========================================================================
  // Command register.
  always_ff @(posedge clk) begin
    if (rst) begin
      underrun_restart <= 1'b0;
      receive_dma_halt <= 1'b0;
      transmit_dma_halt <= 1'b0;
    end else begin
      // Self-clearing pulses.
      underrun_restart <= cmd_wr && wdata[rdc_pkg::CMD_UNDERRUN_RESTART];
      receive_dma_halt <= cmd_wr && wdata[rdc_pkg::CMD_RECEIVE_DMA_HALT];
      transmit_dma_halt <= cmd_wr && wdata[rdc_pkg::CMD_TRANSMIT_DMA_HALT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      skip_current_frame <= 1'b0;
    end else if (cmd_wr && wdata[rdc_pkg::CMD_SKIP_CURRENT_FRAME]) begin
      skip_current_frame <= 1'b1;
    end else if (rx_fetch || (cmd_wr && test_mode)) begin
      skip_current_frame <= 1'b0;
    end
  end

  // The host set wins over a same-cycle hardware clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      receive_descriptors_queued <= 1'b0;
    end else if (cmd_wr && wdata[rdc_pkg::CMD_RX_QUEUED]) begin
      receive_descriptors_queued <= 1'b1;
    end else if ((rx_fetch && rx_host_owned) || (cmd_wr &&
        (wdata[rdc_pkg::CMD_RECEIVE_DMA_HALT] || test_mode))) begin
      receive_descriptors_queued <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_descriptors_queued <= 1'b0;
    end else if (cmd_wr && wdata[rdc_pkg::CMD_TX_QUEUED]) begin
      transmit_descriptors_queued <= 1'b1;
    end else if ((tx_desc_fetch && !tx_desc_owned) || (cmd_wr &&
        (wdata[rdc_pkg::CMD_TRANSMIT_DMA_HALT] || test_mode))) begin
      transmit_descriptors_queued <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      receiver_online <= 1'b0;
    end else if (cmd_wr && wdata[rdc_pkg::CMD_STOP_RX]) begin
      receiver_online <= 1'b0;
    end else if (cmd_wr && wdata[rdc_pkg::CMD_START_RX]) begin
      receiver_online <= 1'b1;
    end
  end

  // ==========================================================================
  // Interrupt status: queue-empty and underrun events, cleared by the
  // matching command bit or by writing one to the status bit.
  function automatic logic next_flag(input logic cur, input logic set,
                                     input logic clr);
    next_flag = set || (cur && !clr);
  endfunction : next_flag

  logic ist_wr;
  assign ist_wr = hit(rdc_pkg::OFF_INTERRUPT_STATUS);

  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_status_reg <= '0;
    end else begin
      interrupt_status_reg[rdc_pkg::IST_RX_QUEUE_EMPTY] <= next_flag(
        interrupt_status_reg[rdc_pkg::IST_RX_QUEUE_EMPTY],
        rx_fetch && rx_host_owned,
        (cmd_wr && wdata[rdc_pkg::CMD_RX_QUEUED]) ||
        (ist_wr && wdata[rdc_pkg::IST_RX_QUEUE_EMPTY]));
      interrupt_status_reg[rdc_pkg::IST_TX_QUEUE_EMPTY] <= next_flag(
        interrupt_status_reg[rdc_pkg::IST_TX_QUEUE_EMPTY],
        tx_desc_fetch && !tx_desc_owned,
        (cmd_wr && wdata[rdc_pkg::CMD_TX_QUEUED]) ||
        (ist_wr && wdata[rdc_pkg::IST_TX_QUEUE_EMPTY]));
      interrupt_status_reg[rdc_pkg::IST_TX_UNDERRUN] <= next_flag(
        interrupt_status_reg[rdc_pkg::IST_TX_UNDERRUN],
        tx_underrun_event,
        (cmd_wr && wdata[rdc_pkg::CMD_UNDERRUN_RESTART]) ||
        (ist_wr && wdata[rdc_pkg::IST_TX_UNDERRUN]));
      // Read-only level, does not interrupt.
      interrupt_status_reg[rdc_pkg::IST_RX_STATUS_VALID] <= rx_status_valid;
    end
  end

  // ==========================================================================
  // Plain read/write control registers. Access-timing restrictions on the
  // initialization, status and test registers are the driver's to keep.
  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_mask <= '0;
      general_control <= '0;
      burst_length_count <= '0;
      receive_config <= '0;
      transmit_config <= '0;
      rx_first_desc <= '0;
      rx_copy_threshold <= '0;
      preemptive_int <= '0;
      tx_first_desc <= '0;
      tx_current_desc <= '0;
      early_tx_threshold <= '0;
    end else begin
      if (hit(rdc_pkg::OFF_INTERRUPT_MASK)) interrupt_mask <= wdata[15:0];
      if (hit(rdc_pkg::OFF_GENERAL_CONTROL)) general_control <= wdata;
      if (hit(rdc_pkg::OFF_BURST_LENGTH_COUNT)) burst_length_count <= wdata;
      if (hit(rdc_pkg::OFF_RECEIVE_CONFIG)) receive_config <= wdata;
      if (hit(rdc_pkg::OFF_TRANSMIT_CONFIG)) transmit_config <= wdata;
      if (hit(rdc_pkg::OFF_RX_FIRST_DESC)) rx_first_desc <= wdata;
      if (hit(rdc_pkg::OFF_RX_COPY_THRESHOLD)) rx_copy_threshold <= wdata;
      if (hit(rdc_pkg::OFF_PREEMPTIVE_INT)) preemptive_int <= wdata;
      if (hit(rdc_pkg::OFF_TX_FIRST_DESC)) tx_first_desc <= wdata;
      if (hit(rdc_pkg::OFF_TX_CURRENT_DESC)) tx_current_desc <= wdata;
      if (hit(rdc_pkg::OFF_EARLY_TX_THRESHOLD)) early_tx_threshold <= wdata;
    end
  end

  // The current receive pointer follows each device-owned fetch, except one that meets a host write in the same cycle, so software sees progress.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_current_desc <= '0;
    end else if (hit(rdc_pkg::OFF_RX_CURRENT_DESC)) begin
      rx_current_desc <= wdata;
    end else if (rx_fetch && !rx_host_owned) begin
      rx_current_desc <= rx_desc.next & rdc_pkg::DW3_ALIGN_MASK;
    end
  end

  // ==========================================================================
  // Control read mux. Reserved command bits read as zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_rdata <= '0;
    end else if (ctl_req.valid && !ctl_req.write) begin
      case (ctl_req.addr)
        rdc_pkg::OFF_DMA_COMMAND: ctl_rdata <= {27'h0000000,
          skip_current_frame, receive_descriptors_queued,
          transmit_descriptors_queued, 2'h0};
        rdc_pkg::OFF_INTERRUPT_STATUS: ctl_rdata <= interrupt_status_reg;
        rdc_pkg::OFF_INTERRUPT_MASK: ctl_rdata <= {16'h0000, interrupt_mask};
        rdc_pkg::OFF_GENERAL_CONTROL: ctl_rdata <= general_control;
        rdc_pkg::OFF_BURST_LENGTH_COUNT: ctl_rdata <= burst_length_count;
        rdc_pkg::OFF_RECEIVE_CONFIG: ctl_rdata <= receive_config;
        rdc_pkg::OFF_TRANSMIT_CONFIG: ctl_rdata <= transmit_config;
        rdc_pkg::OFF_TRANSMIT_STATUS: ctl_rdata <= tx_status_word;
        rdc_pkg::OFF_RX_FIRST_DESC: ctl_rdata <= rx_first_desc;
        rdc_pkg::OFF_RX_CURRENT_DESC: ctl_rdata <= rx_current_desc;
        rdc_pkg::OFF_RX_FRAME_STATUS: ctl_rdata <= rx_status_word;
        rdc_pkg::OFF_RX_COPY_THRESHOLD: ctl_rdata <= rx_copy_threshold;
        rdc_pkg::OFF_PREEMPTIVE_INT: ctl_rdata <= preemptive_int;
        rdc_pkg::OFF_TX_FIRST_DESC: ctl_rdata <= tx_first_desc;
        rdc_pkg::OFF_TX_CURRENT_DESC: ctl_rdata <= tx_current_desc;
        rdc_pkg::OFF_EARLY_TX_THRESHOLD: ctl_rdata <= early_tx_threshold;
        default: ctl_rdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Configuration space: only the interrupt line byte is writable.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_int_line <= '0;
    end else if (cfg_req.valid && cfg_req.write &&
                 cfg_req.addr == rdc_pkg::CFG_OFF_INT_LINE &&
                 cfg_req.be[0]) begin
      cfg_int_line <= {24'h000000, cfg_req.wdata[7:0]};
    end
  end

  // Byte enables are ignored on reads.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata <= '0;
    end else if (cfg_req.valid && !cfg_req.write) begin
      case (cfg_req.addr)
        rdc_pkg::CFG_OFF_ID: cfg_rdata <= rdc_pkg::CFG_ID_VALUE;
        rdc_pkg::CFG_OFF_SUBSYS: cfg_rdata <= rdc_pkg::CFG_SUBSYS_VALUE;
        rdc_pkg::CFG_OFF_INT_LINE: cfg_rdata <= cfg_int_line;
        default: cfg_rdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Checks.
  chk_halt_pulse: assert property (@(posedge clk) disable iff (rst)
    cmd_wr && wdata[rdc_pkg::CMD_RECEIVE_DMA_HALT] &&
    !wdata[rdc_pkg::CMD_RX_QUEUED] |=> receive_dma_halt &&
    !receive_descriptors_queued ##1
    (!receive_dma_halt || $past(cmd_wr)))
    else $error("receive halt did not pulse and clear queued");
  chk_tx_halt: assert property (@(posedge clk) disable iff (rst)
    cmd_wr && wdata[rdc_pkg::CMD_TRANSMIT_DMA_HALT] &&
    !wdata[rdc_pkg::CMD_TX_QUEUED] |=> !transmit_descriptors_queued)
    else $error("transmit halt did not clear queued");
  chk_underrun_clear: assert property (@(posedge clk) disable iff (rst)
    cmd_wr && wdata[rdc_pkg::CMD_UNDERRUN_RESTART] && !tx_underrun_event
    |=> underrun_restart &&
    !interrupt_status_reg[rdc_pkg::IST_TX_UNDERRUN])
    else $error("underrun restart did not clear interrupt");
  chk_rqe_raise: assert property (@(posedge clk) disable iff (rst)
    rx_fetch && rx_host_owned && !(cmd_wr && wdata[rdc_pkg::CMD_RX_QUEUED])
    |=> !receive_descriptors_queued &&
    interrupt_status_reg[rdc_pkg::IST_RX_QUEUE_EMPTY])
    else $error("host owned fetch mishandled");
  chk_skip_clear: assert property (@(posedge clk) disable iff (rst)
    rx_fetch && !cmd_wr |=> !skip_current_frame)
    else $error("skip flag not cleared on fetch");
  chk_online_hold: assert property (@(posedge clk) disable iff (rst)
    receiver_online && !(cmd_wr && wdata[rdc_pkg::CMD_STOP_RX])
    |=> receiver_online)
    else $error("receiver dropped offline without stop");
  chk_cmd_readback: assert property (@(posedge clk) disable iff (rst)
    ctl_req.valid && !ctl_req.write &&
    ctl_req.addr == rdc_pkg::OFF_DMA_COMMAND
    |=> ctl_rdata[7:5] == 3'h0 && ctl_rdata[1:0] == 2'h0)
    else $error("write-only command bits read nonzero");
  chk_owned_queued: assert property (@(posedge clk) disable iff (rst)
    rx_fetch && !rx_host_owned |=> rx_job_valid)
    else $error("owned descriptor not queued");
  chk_job_decode: assert property (@(posedge clk) disable iff (rst)
    rx_job_valid && rx_job.fragment_list |-> rx_job.length == 16'h0000 &&
    rx_job.next_desc[1:0] == 2'h0)
    else $error("descriptor job decoded wrongly");
  chk_cfg_unused: assert property (@(posedge clk) disable iff (rst)
    cfg_req.valid && !cfg_req.write && cfg_req.addr == 8'h40
    |=> cfg_rdata == 32'h0000_0000)
    else $error("unused config location not zero");
endmodule : rdc_dma_command

// ### pkg/rdc_pkg.sv
/*
  Shared constants and carrier types for the receive descriptor and DMA
  command block. Assumes a single 25 MHz clock and a synchronous reset.
*/
package rdc_pkg;
  // ==========================================================================
  // Register offsets (byte addresses, control map).
  localparam logic [7:0] OFF_DMA_COMMAND = 8'h00;
  localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h04;
  localparam logic [7:0] OFF_INTERRUPT_MASK = 8'h08;
  localparam logic [7:0] OFF_GENERAL_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_BURST_LENGTH_COUNT = 8'h18;
  localparam logic [7:0] OFF_RECEIVE_CONFIG = 8'h60;
  localparam logic [7:0] OFF_TRANSMIT_CONFIG = 8'h70;
  localparam logic [7:0] OFF_TRANSMIT_STATUS = 8'h74;
  localparam logic [7:0] OFF_RX_FIRST_DESC = 8'h80;
  localparam logic [7:0] OFF_RX_CURRENT_DESC = 8'h84;
  localparam logic [7:0] OFF_RX_FRAME_STATUS = 8'ha4;
  localparam logic [7:0] OFF_RX_COPY_THRESHOLD = 8'hb0;
  localparam logic [7:0] OFF_PREEMPTIVE_INT = 8'hbc;
  localparam logic [7:0] OFF_TX_FIRST_DESC = 8'hc0;
  localparam logic [7:0] OFF_TX_CURRENT_DESC = 8'hc4;
  localparam logic [7:0] OFF_EARLY_TX_THRESHOLD = 8'hdc;
  // Configuration space offsets.
  localparam logic [7:0] CFG_OFF_ID = 8'h00;
  localparam logic [7:0] CFG_OFF_SUBSYS = 8'h2c;
  localparam logic [7:0] CFG_OFF_INT_LINE = 8'h3c;

  // ==========================================================================
  // Command register bits.
  localparam int CMD_UNDERRUN_RESTART = 7;
  localparam int CMD_RECEIVE_DMA_HALT = 6;
  localparam int CMD_TRANSMIT_DMA_HALT = 5;
  localparam int CMD_SKIP_CURRENT_FRAME = 4;
  localparam int CMD_RX_QUEUED = 3;
  localparam int CMD_TX_QUEUED = 2;
  localparam int CMD_START_RX = 1;
  localparam int CMD_STOP_RX = 0;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;

  // Interrupt status bits.
  localparam int IST_RX_STATUS_VALID = 23;
  localparam int IST_TX_UNDERRUN = 8;
  localparam int IST_TX_QUEUE_EMPTY = 7;
  localparam int IST_RX_QUEUE_EMPTY = 2;
  localparam logic [31:0] IMASK_USED = 32'h0000_ffff;

  // Receive descriptor word 0, word 2 and word 3 fields.
  localparam int DW0_OWNER = 15;
  localparam int DW2_HEADER_COPY = 18;
  localparam int DW2_LENGTH_FIRST = 17;
  localparam int DW2_FRAGMENT_LIST = 16;
  localparam logic [31:0] DW3_ALIGN_MASK = 32'hffff_fffc;

  // Arbitrary identification values, chosen only to be neutral.
  localparam logic [31:0] CFG_ID_VALUE = 32'h0001_0001;
  localparam logic [31:0] CFG_SUBSYS_VALUE = 32'h0001_0001;

  localparam int FIFO_DEPTH = 8;

  // ==========================================================================
  // Carrier types.
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] buffer;
    logic [31:0] control;
    logic [31:0] next;
  } rdc_desc_type;

  typedef struct packed {
    logic header_copy;
    logic length_first;
    logic fragment_list;
    logic [15:0] length;
    logic [15:0] offset;
    logic [31:0] address;
    logic [31:0] next_desc;
  } rdc_job_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } rdc_req_type;
endpackage : rdc_pkg

// ### hdl/rdc_fifo.sv
/*
  Parameterised flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module rdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rdc_fifo

// ### tb/rdc_fetch_model.sv
/* Descriptor fetch engine and job sink model for the DMA command block.
   Assumes the bench calls send and drives stall through the hierarchy. */
`timescale 1ns/1ps
module rdc_fetch_model (
  input wire logic clk,
  input wire logic rx_desc_ready,
  output logic rx_desc_valid,
  output rdc_pkg::rdc_desc_type rx_desc,
  output logic rx_job_ready,
  output logic lost
);
  logic stall = 1'b1;
  initial begin
    rx_desc_valid = 1'b0;
    rx_desc = '0;
    lost = 1'b0;
  end
  assign rx_job_ready = !stall;
  // ==========================================================================
  // Handshake. Released words are inverted so stale data is never reused,
  // but keep the owner bit set so an idle bus never looks host-owned.
  task send(input rdc_pkg::rdc_desc_type d);
    int n;
    @(posedge clk);
    #1;
    rx_desc_valid = 1'b1;
    rx_desc = d;
    n = 0;
    while (!rx_desc_ready && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20) lost = 1'b1;
    @(posedge clk);
    #1;
    rx_desc_valid = 1'b0;
    rx_desc = ~d | {32'h0000_8000, 96'h0};
  endtask : send
endmodule : rdc_fetch_model

// ### tb/rx_descriptor_and_dma_command_tb.sv
/* Self-checking bench for the DMA command block.
   Assumes the fetch model file is compiled first. */
`timescale 1ns/1ps
module rx_descriptor_and_dma_command_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic test_mode = 1'b0;
  logic tx_underrun_event = 1'b0;
  logic tx_desc_fetch = 1'b0;
  logic rx_status_valid = 1'b0;
  rdc_pkg::rdc_req_type ctl_req = '0;
  rdc_pkg::rdc_req_type cfg_req = '0;
  logic [31:0] ctl_rdata, cfg_rdata, q;
  logic rx_desc_valid, rx_desc_ready, rx_job_valid, rx_job_ready, lost;
  logic receiver_online, receive_dma_halt, transmit_dma_halt;
  logic underrun_restart;
  rdc_pkg::rdc_desc_type rx_desc;
  rdc_pkg::rdc_job_type rx_job;
  int n_fail = 0;
  int compares = 0;
  always #20 clk = ~clk;
  rdc_fetch_model i_mem (.clk(clk), .rx_desc_ready(rx_desc_ready),
    .rx_desc_valid(rx_desc_valid), .rx_desc(rx_desc),
    .rx_job_ready(rx_job_ready), .lost(lost));
  rdc_dma_command i_dut (.clk(clk), .rst(rst), .ctl_req(ctl_req),
    .ctl_rdata(ctl_rdata), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .test_mode(test_mode), .rx_desc_valid(rx_desc_valid),
    .rx_desc_ready(rx_desc_ready), .rx_desc(rx_desc),
    .rx_job_valid(rx_job_valid), .rx_job_ready(rx_job_ready),
    .rx_job(rx_job), .rx_owned_fetch(), .tx_desc_fetch(tx_desc_fetch),
    .tx_desc_owned(1'b0), .tx_underrun_event(tx_underrun_event),
    .rx_status_valid(rx_status_valid), .rx_status_word(32'h0000_5a5a),
    .tx_status_word(32'h0000_a5a5), .receiver_online(receiver_online),
    .receive_dma_halt(receive_dma_halt),
    .transmit_dma_halt(transmit_dma_halt),
    .underrun_restart(underrun_restart), .skip_current_frame(),
    .receive_descriptors_queued(), .transmit_descriptors_queued());
  // ==========================================================================
  // Access and compare tasks.
  task conclude;
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task acc(input logic c, input logic w, input logic [7:0] a,
           input logic [31:0] d, input logic [3:0] be);
    rdc_pkg::rdc_req_type r;
    r = '{1'b1, w, a, d, be};
    @(posedge clk);
    #1;
    if (c) cfg_req = r;
    else ctl_req = r;
    @(posedge clk);
    #1;
    cfg_req = '0;
    ctl_req = '0;
    q = c ? cfg_rdata : ctl_rdata;
  endtask : acc
  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b0, 1'b1, a, d, 4'hf);
  endtask : wr
  task rd(input logic [7:0] a);
    acc(1'b0, 1'b0, a, 32'h0, 4'hf);
  endtask : rd
  // Next pointers carry stray low bits on purpose; the device must drop them.
  function automatic rdc_pkg::rdc_desc_type mk(input int i);
    return '{32'h0000_8000, 32'h1000_0001 + i,
      {13'h0, i[2:0], 16'h0040 + 16'(i)}, 32'h2000_0103 + (i << 4)};
  endfunction : mk
  task pop(input int i);
    rdc_pkg::rdc_desc_type d;
    int n;
    d = mk(i);
    n = 0;
    while (rx_job_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (n == 20) begin
      n_fail++;
      conclude();
    end
    chk(rx_job.address, d.buffer);
    chk({29'h0, rx_job.header_copy, rx_job.length_first,
      rx_job.fragment_list}, {29'h0, d.control[18:16]});
    chk(d.control[16] ? rx_job.offset : rx_job.length, d.control[15:0]);
    chk(rx_job.next_desc, d.next & 32'hffff_fffc);
    i_mem.stall = 1'b0;
    @(posedge clk);
    #1;
    i_mem.stall = 1'b1;
  endtask : pop
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    wr(8'h60, 32'h0000_0a0a);
    rd(8'h60);
    chk(q, 32'h0000_0a0a);
    rd(8'h00);
    chk(q, rdc_pkg::CMD_RESET);
    wr(8'h00, 32'h0000_0002);
    chk({31'h0, receiver_online}, 32'h1);
    wr(8'h00, 32'h0000_0001);
    chk({31'h0, receiver_online}, 32'h0);
    wr(8'h00, 32'h0000_001c);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00);
    chk(q, 32'h0000_001c);
    wr(8'h00, 32'h0000_0040);
    chk({31'h0, receive_dma_halt}, 32'h1);
    wr(8'h00, 32'h0000_0020);
    chk({31'h0, transmit_dma_halt}, 32'h1);
    rd(8'h00);
    chk(q, 32'h0000_0010);
    test_mode = 1'b1;
    wr(8'h00, 32'h0000_000c);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00);
    chk(q, 32'h0000_0000);
    test_mode = 1'b0;
    wr(8'h00, 32'h0000_0018);
    i_mem.send('0);
    rd(8'h00);
    chk(q, 32'h0000_0000);
    chk({31'h0, rx_job_valid}, 32'h0);
    rd(8'h04);
    chk({31'h0, q[2]}, 32'h1);
    wr(8'h00, 32'h0000_0008);
    rd(8'h04);
    chk({31'h0, q[2]}, 32'h0);
    wr(8'h00, 32'h0000_0004);
    @(posedge clk);
    #1;
    tx_underrun_event = 1'b1;
    tx_desc_fetch = 1'b1;
    @(posedge clk);
    #1;
    tx_underrun_event = 1'b0;
    tx_desc_fetch = 1'b0;
    rd(8'h04);
    chk({31'h0, q[8]}, 32'h1);
    chk({31'h0, q[7]}, 32'h1);
    rd(8'h74);
    chk(q, 32'h0000_a5a5);
    rd(8'h00);
    chk(q, 32'h0000_0008);
    wr(8'h00, 32'h0000_0080);
    chk({31'h0, underrun_restart}, 32'h1);
    rd(8'h04);
    chk({31'h0, q[8]}, 32'h0);
    rx_status_valid = 1'b1;
    rd(8'h04);
    chk({31'h0, q[23]}, 32'h1);
    rd(8'ha4);
    chk(q, 32'h0000_5a5a);
    test_mode = 1'b1;
    rd(8'h1c);
    chk(q, 32'h0000_0000);
    test_mode = 1'b0;
    acc(1'b1, 1'b0, 8'h00, 32'h0, 4'h1);
    chk(q, rdc_pkg::CFG_ID_VALUE);
    acc(1'b1, 1'b1, 8'h34, 32'hffff_ffff, 4'hf);
    acc(1'b1, 1'b0, 8'h34, 32'h0, 4'h2);
    chk(q, 32'h0000_0000);
    acc(1'b1, 1'b0, 8'h40, 32'h0, 4'hf);
    chk(q, 32'h0000_0000);
    for (int i = 0; i < 8; i++) i_mem.send(mk(i));
    #1;
    chk({31'h0, rx_desc_ready}, 32'h0);
    chk({31'h0, lost}, 32'h0);
    for (int i = 0; i < 8; i++) pop(i);
    chk({31'h0, rx_job_valid}, 32'h0);
    conclude();
  end
endmodule : rx_descriptor_and_dma_command_tb
